// File: design/pss_pkg.sv
// package for the parallel-in serial-out shifter: widths, reset values, carriers
// Notes on behaviour
// - eight stages shift first toward last
// - eight parallel inputs, used only while load low
// - outputs last stage true and inverted
// - two clocks NOR-combined, either high inhibits
// - one clock low lets other rising edges shift
// - parallel inputs ignored while load high
// - load falling copies parallel inputs regardless
// - load low, stages follow parallel inputs
// - enabled rising edge: serial in, predecessor shift
package pss_pkg;
  localparam int PSS_STAGES = 8;
  localparam logic [7:0] PSS_STAGE_RST = 8'h00;
  // combined clock starts out high, so a pin idling high gives no false edge
  localparam logic PSS_OR_RST = 1'h1;
  localparam int PSS_FIRST = 0;
  localparam int PSS_LAST = PSS_STAGES - 1;

  // pin-side control inputs travel together
  typedef struct packed {
    logic load_n;
    logic clk_a;
    logic clk_b;
    logic serial;
  } pss_ctrl_t;

  // load reads low after reset, both clock pins read as inhibited
  localparam pss_ctrl_t PSS_CTRL_RST = 4'h6;
endpackage

// File: design/pss_shifter.sv
// eight-stage parallel-in serial-out shift register sampled on the system clock
`timescale 1ns/1ps
module pss_shifter
  import pss_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic nrst,
  // pins from the controller
  input wire pss_ctrl_t ctrl,
  input wire logic [PSS_STAGES-1:0] par_in,
  // serial outputs
  output logic ser_out_q,
  output logic ser_out_n_q
);

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for all pins
  pss_ctrl_t ctrl_s1_q;
  pss_ctrl_t ctrl_s2_q;
  logic [PSS_STAGES-1:0] par_s1_q;
  logic [PSS_STAGES-1:0] par_s2_q;

  // control pins: load reads low until the pins arrive, clocks read as inhibited
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_s1_q <= PSS_CTRL_RST;
      ctrl_s2_q <= PSS_CTRL_RST;
    end
    else
    begin
      ctrl_s1_q <= ctrl;
      ctrl_s2_q <= ctrl_s1_q;
    end
  end

  // parallel data pins
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      par_s1_q <= PSS_STAGE_RST;
      par_s2_q <= PSS_STAGE_RST;
    end
    else
    begin
      par_s1_q <= par_in;
      par_s2_q <= par_s1_q;
    end
  end

  // only the second flop of each synchroniser is read below
  pss_ctrl_t cs;
  assign cs = ctrl_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // gated clock: NOR of both clock pins; a falling NOR output shifts
  logic gclk;
  logic clk_or;
  logic clk_or_q;
  logic shift_en;

  // either pin high holds the NOR output low and blocks every shift
  assign gclk = ~(cs.clk_a | cs.clk_b);
  // a rising edge on the active pin is a falling edge on the NOR output
  assign clk_or = ~gclk;
  assign shift_en = cs.load_n && clk_or && !clk_or_q;

  // previous level of the combined clock, reset to the inhibited level
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      clk_or_q <= PSS_OR_RST;
    else
      clk_or_q <= clk_or;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage chain
  logic [PSS_STAGES-1:0] stage_q;
  logic [PSS_STAGES-1:0] stage_d;
  logic [PSS_STAGES-1:0] shift_src;

  // per stage: load wins over shift, and with neither the stage holds
  for (genvar g = 0; g < PSS_STAGES; g++)
  begin : g_stage
    if (g == PSS_FIRST)
    begin : g_head
      // the first stage takes the serial pin
      assign shift_src[g] = cs.serial;
    end
    else
    begin : g_link
      // every later stage takes its predecessor
      assign shift_src[g] = stage_q[g-1];

      chk_stage_link: assert property (@(posedge clock) disable iff (!nrst)
        shift_en |=> stage_q[g] == $past(stage_q[g-1]))
        else $error("stage did not take its predecessor");
    end

    assign stage_d[g] = !cs.load_n ? par_s2_q[g] : (shift_en ? shift_src[g] : stage_q[g]);

    chk_stage_load: assert property (@(posedge clock) disable iff (!nrst)
      !cs.load_n |=> stage_q[g] == $past(par_s2_q[g]))
      else $error("stage did not follow its parallel input");
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      stage_q <= PSS_STAGE_RST;
    else
      stage_q <= stage_d;
  end

  // outputs track the last stage's next value so they change with it
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_out_q <= PSS_STAGE_RST[PSS_LAST];
      ser_out_n_q <= ~PSS_STAGE_RST[PSS_LAST];
    end
    else
    begin
      ser_out_q <= stage_d[PSS_LAST];
      ser_out_n_q <= ~stage_d[PSS_LAST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the serial outputs
  chk_out_compl: assert property (@(posedge clock) disable iff (!nrst)
    ser_out_n_q == ~ser_out_q) else $error("inverted output not complement");

  chk_out_last: assert property (@(posedge clock) disable iff (!nrst)
    ser_out_q == stage_q[PSS_LAST]) else $error("output does not follow last stage");

  chk_out_shift: assert property (@(posedge clock) disable iff (!nrst)
    shift_en |=> ser_out_q == $past(stage_q[PSS_LAST-1]))
    else $error("output did not move with the shift");

  chk_out_n_shift: assert property (@(posedge clock) disable iff (!nrst)
    shift_en |=> ser_out_n_q == !$past(stage_q[PSS_LAST-1]))
    else $error("inverted output did not move with the shift");

  chk_out_load: assert property (@(posedge clock) disable iff (!nrst)
    !cs.load_n |=> ser_out_n_q == !$past(par_s2_q[PSS_LAST]))
    else $error("inverted output did not follow a load");

  chk_out_hold: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !shift_en |=> $stable(ser_out_q))
    else $error("output changed without load or shift");

  ////////////////////////////////////////////////////////////////////////////
  // checks on loading and shifting

  chk_load_follow: assert property (@(posedge clock) disable iff (!nrst)
    !cs.load_n |=> stage_q == $past(par_s2_q)) else $error("stages not loaded");

  chk_shift_step: assert property (@(posedge clock) disable iff (!nrst)
    shift_en |=> stage_q == {$past(stage_q[PSS_LAST-1:0]), $past(cs.serial)})
    else $error("shift step wrong");

  chk_hold_idle: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !shift_en |=> $stable(stage_q)) else $error("stages changed without edge");

  chk_inhibit_b: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && cs.clk_b && $past(cs.clk_b) |=> $stable(stage_q))
    else $error("shift while second clock pin held high");

  chk_inhibit_a: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && cs.clk_a && $past(cs.clk_a) |=> $stable(stage_q))
    else $error("shift while first clock pin held high");

  chk_par_ignored: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !shift_en && $changed(par_s2_q) |=> $stable(stage_q))
    else $error("parallel inputs used while load high");

  chk_load_fall: assert property (@(posedge clock) disable iff (!nrst)
    $fell(cs.load_n) && shift_en == 1'b0 |=> stage_q == $past(par_s2_q))
    else $error("load edge did not copy inputs");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the clock gate

  chk_enable_a: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !cs.clk_b && !$past(cs.clk_b) && $rose(cs.clk_a) |=> stage_q[PSS_FIRST] == $past(cs.serial))
    else $error("rising first clock pin did not shift");

  chk_enable_b: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !cs.clk_a && !$past(cs.clk_a) && $rose(cs.clk_b) |=> stage_q[PSS_FIRST] == $past(cs.serial))
    else $error("rising second clock pin did not shift");

  chk_single_shift: assert property (@(posedge clock) disable iff (!nrst)
    shift_en |=> !shift_en)
    else $error("more than one shift for one clock edge");

  chk_fall_hold: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && $fell(clk_or) |=> $stable(stage_q))
    else $error("falling clock pin shifted");

  chk_hold_low: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !cs.clk_a && !cs.clk_b |=> $stable(stage_q))
    else $error("stages changed with both clock pins low");

  chk_hold_serial: assert property (@(posedge clock) disable iff (!nrst)
    cs.load_n && !shift_en && $changed(cs.serial) |=> $stable(stage_q))
    else $error("serial pin used without a clock edge");

  chk_load_wins: assert property (@(posedge clock) disable iff (!nrst)
    !cs.load_n && clk_or && !clk_or_q |=> stage_q == $past(par_s2_q))
    else $error("clock edge overrode a load");

  chk_load_serial: assert property (@(posedge clock) disable iff (!nrst)
    !cs.load_n && $changed(cs.serial) |=> stage_q == $past(par_s2_q))
    else $error("serial pin disturbed a load");

endmodule

// File: sim/pss_host.sv
// host controller model driving load, clocks and data pins
`timescale 1ns/1ps
module pss_host
  import pss_pkg::*;
(
  // system
  input wire logic clock,
  // pins to the shifter
  output pss_ctrl_t ctrl,
  output logic [PSS_STAGES-1:0] par_in
);
  initial
  begin
    ctrl = pss_ctrl_t'(4'h8);
    par_in = 8'h00;
  end
  // each pin setting holds four clock periods, longer than the sync latency
  task automatic pins(input pss_ctrl_t c, input logic [7:0] p);
    @(negedge clock);
    ctrl = c;
    par_in = p;
    repeat (3) @(negedge clock);
  endtask
  // inhibit goes high only once the active clock is already high
  task automatic inhibit_on();
    pins(pss_ctrl_t'(4'hD), par_in);
    pins(pss_ctrl_t'(4'hE), par_in);
  endtask
endmodule

// File: sim/tb_top.sv
// testbench for the shifter: load, hold, shift and inhibit scenarios
`timescale 1ns/1ps
module tb_top
  import pss_pkg::*;
;
  logic clock;
  logic nrst;
  pss_ctrl_t ctrl;
  logic [PSS_STAGES-1:0] par_in;
  logic ser_out_q;
  logic ser_out_n_q;
  logic [7:0] model;
  int n_fail;
  int n_checks;
  pss_host host (.clock(clock), .ctrl(ctrl), .par_in(par_in));
  pss_shifter dut (.clock(clock), .nrst(nrst), .ctrl(ctrl), .par_in(par_in), .ser_out_q(ser_out_q),
    .ser_out_n_q(ser_out_n_q));
  initial
  begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  task automatic chk();
    n_checks++;
    if (ser_out_q !== model[7] || ser_out_n_q !== ~model[7])
    begin
      n_fail++;
      $display("mismatch %0t %h %h", $time, {ser_out_q, ser_out_n_q}, {model[7], ~model[7]});
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic load_follow();
    host.pins(pss_ctrl_t'(4'h7), 8'hA5);
    model = 8'hA5;
    chk();
    host.pins(pss_ctrl_t'(4'h7), 8'h3C);
    model = 8'h3C;
    chk();
    host.pins(pss_ctrl_t'(4'h8), 8'hFF);
    chk();
  endtask
  task automatic shift_a();
    for (int i = 0; i < 8; i++)
    begin
      host.pins(pss_ctrl_t'({3'h6, i[0]}), 8'h00);
      host.pins(pss_ctrl_t'({3'h4, i[0]}), 8'h00);
      model = {model[6:0], i[0]};
      chk();
    end
  endtask
  task automatic inhibit_b();
    host.inhibit_on();
    model = {model[6:0], 1'h1};
    host.pins(pss_ctrl_t'(4'hA), 8'h00);
    host.pins(pss_ctrl_t'(4'hE), 8'h00);
    chk();
    host.pins(pss_ctrl_t'(4'h8), 8'h00);
    host.pins(pss_ctrl_t'(4'hA), 8'h00);
    host.pins(pss_ctrl_t'(4'h8), 8'h00);
    model = {model[6:0], 1'h0};
    chk();
  endtask
  // three patterns give every stage a distinct code, shifted out on the second clock pin
  task automatic par_walk();
    logic [7:0] pats [3];
    pats = '{8'h0F, 8'h33, 8'h55};
    for (int k = 0; k < 3; k++)
    begin
      host.pins(pss_ctrl_t'(4'h0), pats[k]);
      model = pats[k];
      chk();
      host.pins(pss_ctrl_t'(4'h8), 8'hFF);
      chk();
      for (int j = 0; j < 7; j++)
      begin
        host.pins(pss_ctrl_t'(4'hB), 8'hFF);
        host.pins(pss_ctrl_t'(4'h8), 8'hFF);
        model = {model[6:0], 1'h1};
        chk();
      end
    end
  endtask
  // reset in mid-run, then a load must still land
  task automatic reset_mid();
    @(negedge clock);
    nrst = 1'h0;
    model = 8'h00;
    @(negedge clock);
    chk();
    @(negedge clock);
    nrst = 1'h1;
    host.pins(pss_ctrl_t'(4'h7), 8'h81);
    model = 8'h81;
    chk();
    host.pins(pss_ctrl_t'(4'h8), 8'h00);
    chk();
  endtask
  initial
  begin
    nrst = 1'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(negedge clock);
    nrst = 1'h1;
    load_follow();
    shift_a();
    inhibit_b();
    par_walk();
    reset_mid();
    wrap_up();
  end
  initial
  begin
    repeat (2000) @(posedge clock);
    n_fail++;
    wrap_up();
  end
endmodule
